// ==== src/fan_pwm_tach_params.svh ====
`ifndef FAN_PWM_TACH_PARAMS_SVH
`define FAN_PWM_TACH_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SMOOTH          10'h045
`define IDX_CFG             10'h04A
`define IDX_DUTY            10'h04C
`define IDX_LUT_FIRST       10'h050
`define IDX_LUT_LAST        10'h067
`define IDX_TACH_READ       10'h070
`define IDX_TACH_LIMIT      10'h071
`define IDX_IRQ_STATUS      10'h072
`define IDX_IRQ_MASK        10'h073

`define LUT_ENTRIES         24
`define LUT_STEPS           12

`define CFG_RESET           8'h20
`define CFG_WRITE_MASK      8'h3F
`define SMOOTH_RESET        3'h0
`define DUTY_RESET          8'h00
`define LUT_RESET           8'h00
`define TACH_READ_RESET     16'h0000
`define TACH_LIMIT_RESET    16'hFFFF
`define TACH_SATURATED      16'hFFFF
`define IRQ_RESET           2'h0
`define IRQ_OVER_BIT        0
`define IRQ_LOST_BIT        1
`define DUTY_FULL           8'hFF
`define MIN_ON_DUTY         8'h10

`define MCLK_HZ             25000000
`define FAST_BASE_HZ        360000
`define SLOW_BASE_HZ        1400
`define FAST_DIV            (`MCLK_HZ / `FAST_BASE_HZ)
`define SLOW_DIV            (`MCLK_HZ / `SLOW_BASE_HZ)

`endif

// ==== src/fan_pwm_tach_pkg.sv ====
package fan_pwm_tach_pkg;

    `include "fan_pwm_tach_params.svh"

    typedef enum logic [1:0]
    {
        mode_plain,
        mode_flag_low,
        mode_accurate,
        mode_gentle
    } rpm_sense_mode_t;

    typedef struct packed
    {
        logic [1:0]      spare;
        logic            duty_program_unlock;
        logic            fan_output_polarity;
        logic            pwm_base_clock_select;
        logic            reserved_bit;
        rpm_sense_mode_t rpm_sense_mode;
    } pwm_cfg_t;

    typedef struct packed
    {
        logic [7:0]      duty;
        logic            pwm_base_clock_select;
        rpm_sense_mode_t rpm_sense_mode;
    } pwm_ctrl_t;

    typedef struct packed
    {
        logic [15:0]     count;
        logic            valid;
        logic            lost;
    } tach_report_t;

    typedef logic [7:0] lut_image_t [`LUT_ENTRIES];

endpackage

// ==== src/fan_pwm_core.sv ====
`timescale 1ns/100ps
`include "fan_pwm_tach_params.svh"

module fan_pwm_core
#(
    parameter int unsigned SLOW_DIV = `SLOW_DIV
)
(
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire fan_pwm_tach_pkg::pwm_ctrl_t  ctrl,
    input  wire logic                         tach_in,
    output logic                              pwm_on,
    output fan_pwm_tach_pkg::tach_report_t    report
);
    import fan_pwm_tach_pkg::*;

    logic [15:0] div_cnt;
    logic [15:0] div_limit;
    logic        base_tick;
    logic [7:0]  period_cnt;
    logic        measure_period;
    logic [7:0]  duty_eff;
    logic        tach_prev;
    logic        tach_rise;
    logic [15:0] tach_cnt;
    logic        tach_held;

    assign div_limit = ctrl.pwm_base_clock_select ? 16'(SLOW_DIV - 1) : 16'(`FAST_DIV - 1); // R5
    assign tach_rise = tach_in & ~tach_prev;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            div_cnt   <= 16'h0000;
            base_tick <= 1'b0;
        end
        else if (div_cnt >= div_limit)
        begin
            div_cnt   <= 16'h0000;
            base_tick <= 1'b1;
        end
        else
        begin
            div_cnt   <= div_cnt + 16'h0001;
            base_tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            period_cnt     <= 8'h00;
            measure_period <= 1'b0;
        end
        else if (base_tick)
        begin
            period_cnt <= period_cnt + 8'h01;
            if (period_cnt == 8'hFF)
            begin
                measure_period <= ~measure_period;
            end
        end
    end

    // Accurate mode spends every other period fully on so the tach pulses are clean.
    always_comb
    begin
        unique case (ctrl.rpm_sense_mode)
            mode_plain:    duty_eff = ctrl.duty; // R7
            mode_flag_low: duty_eff = ctrl.duty; // R8
            mode_accurate: duty_eff = measure_period ? `DUTY_FULL : ctrl.duty; // R9
            mode_gentle:   duty_eff = (ctrl.duty < `MIN_ON_DUTY) ? `MIN_ON_DUTY : ctrl.duty; // R10
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pwm_on <= 1'b0;
        end
        else
        begin
            pwm_on <= (duty_eff == `DUTY_FULL) | (period_cnt < duty_eff);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tach_prev    <= 1'b0;
            tach_cnt     <= 16'h0000;
            tach_held    <= 1'b0;
            report       <= '0;
        end
        else
        begin
            tach_prev    <= tach_in;
            report.valid <= 1'b0;
            report.lost  <= 1'b0;
            if (tach_rise)
            begin
                report.count <= tach_held ? `TACH_SATURATED : tach_cnt;
                report.valid <= 1'b1;
                tach_cnt     <= 16'h0000;
                tach_held    <= 1'b0;
            end
            else if (base_tick)
            begin
                if (tach_cnt != `TACH_SATURATED)
                begin
                    tach_cnt <= tach_cnt + 16'h0001;
                end
                else if (ctrl.rpm_sense_mode == mode_plain)
                begin
                    tach_cnt <= 16'h0000; // R7
                end
                else if (!tach_held)
                begin
                    report.count <= `TACH_SATURATED; // R8 R9 R10
                    report.valid <= 1'b1;
                    report.lost  <= 1'b1;
                    tach_held    <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== src/fan_pwm_tach_config.sv ====
`timescale 1ns/100ps
`include "fan_pwm_tach_params.svh"

// Overview of operation
// (R1) Configuration bits 7 and 6 always read back as zero.
// (R2) Locked: duty, smoothing and table are read-only; duty follows temperature via table.
// (R3) Unlock bit, reset to one, opens those registers; a duty write sets the output.
// (R4) Polarity zero pulls the fan pin low for off; one pulls low for on.
// (R5) Clock select zero runs the PWM from 360 kHz, one from 1.4 kHz.
// (R6) Software always writes zero into reserved configuration bit 2.
// (R7) Tach mode 00 counts plainly; slow fans may give false wrapped readings.
// (R8) Mode 01 keeps duty, reports FFFFh when too slow; may flag an error.
// (R9) Mode 10 alters duty for accurate readings and reports FFFFh when too slow.
// (R10) Mode 11 alters duty least and reports FFFFh when too slow.
// (R11) With the 360 kHz clock selected the tach always runs in mode 00.
module fan_pwm_tach_config
#(
    parameter int unsigned SLOW_DIV = `SLOW_DIV
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  remote_temp,
    input  wire logic        tach_in,
    output logic             fan_pwm_out,
    output logic             fan_pwm_oe,
    output logic [2:0]       smoothing_setting,
    output logic             irq
);
    import fan_pwm_tach_pkg::*;

    pwm_cfg_t     cfg;
    logic [2:0]   smooth;
    logic [7:0]   duty;
    lut_image_t   lut;
    logic [15:0]  tach_read;
    logic [15:0]  tach_limit;
    logic [1:0]   irq_status;
    logic [1:0]   irq_mask;
    logic [9:0]   idx;
    logic [4:0]   lut_sel;
    logic         access;
    logic         answer;
    logic         wr_done;
    logic         unlocked;
    logic [31:0]  next_prdata;
    logic [7:0]   next_duty;
    logic [1:0]   irq_set;
    logic [1:0]   irq_clear;
    pwm_ctrl_t    ctrl;
    logic         pwm_on;
    tach_report_t report;

    function automatic logic reg_mapped(input logic [11:0] addr);
        logic [9:0] i;
        i = addr[11:2];
        reg_mapped = (addr[1:0] == 2'h0)
                   & ((i == `IDX_SMOOTH) | (i == `IDX_CFG) | (i == `IDX_DUTY)
                   | ((i >= `IDX_LUT_FIRST) & (i <= `IDX_LUT_LAST))
                   | (i == `IDX_TACH_READ) | (i == `IDX_TACH_LIMIT)
                   | (i == `IDX_IRQ_STATUS) | (i == `IDX_IRQ_MASK));
    endfunction

    function automatic logic is_lut(input logic [9:0] i);
        is_lut = (i >= `IDX_LUT_FIRST) & (i <= `IDX_LUT_LAST);
    endfunction

    // Even table entries are temperature thresholds, odd ones the duty for that step.
    function automatic logic [7:0] lut_duty(input lut_image_t image, input logic [7:0] temp);
        logic [7:0] result;
        result = 8'h00;
        for (int s = 0; s < `LUT_STEPS; s++)
        begin
            if (temp >= image[2 * s])
            begin
                result = image[2 * s + 1];
            end
        end
        return result;
    endfunction

    assign idx      = paddr[11:2];
    assign lut_sel  = 5'(idx - `IDX_LUT_FIRST);
    assign access   = psel & penable;
    assign answer   = access & ~pready;
    assign wr_done  = access & pready & pwrite & reg_mapped(paddr);
    assign unlocked = cfg.duty_program_unlock;

    // One wait state: pready rises in the second access cycle, so all outputs stay registered.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= answer;
            pslverr <= answer & ~reg_mapped(paddr);
            prdata  <= answer ? next_prdata : 32'h0000_0000;
        end
    end

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (!pwrite && reg_mapped(paddr))
        begin
            if (idx == `IDX_SMOOTH)
            begin
                next_prdata = {29'h0000_0000, smooth};
            end
            else if (idx == `IDX_CFG)
            begin
                next_prdata = {24'h00_0000, 2'b00, cfg[5:0]}; // R1
            end
            else if (idx == `IDX_DUTY)
            begin
                next_prdata = {24'h00_0000, duty};
            end
            else if (is_lut(idx))
            begin
                next_prdata = {24'h00_0000, lut[lut_sel]};
            end
            else if (idx == `IDX_TACH_READ)
            begin
                next_prdata = {16'h0000, tach_read};
            end
            else if (idx == `IDX_TACH_LIMIT)
            begin
                next_prdata = {16'h0000, tach_limit};
            end
            else if (idx == `IDX_IRQ_STATUS)
            begin
                next_prdata = {30'h0000_0000, irq_status};
            end
            else
            begin
                next_prdata = {30'h0000_0000, irq_mask};
            end
        end
    end

    // Bit 2 is kept as written; software is expected to leave it zero.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cfg <= `CFG_RESET; // R3
        end
        else if (wr_done && idx == `IDX_CFG)
        begin
            cfg <= pwdata[7:0] & `CFG_WRITE_MASK; // R1
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            smooth <= `SMOOTH_RESET;
        end
        else if (wr_done && idx == `IDX_SMOOTH && unlocked)
        begin
            smooth <= pwdata[2:0]; // R2 R3
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int e = 0; e < `LUT_ENTRIES; e++)
            begin
                lut[e] <= `LUT_RESET;
            end
        end
        else if (wr_done && is_lut(idx) && unlocked)
        begin
            lut[lut_sel] <= pwdata[7:0]; // R2 R3
        end
    end

    // While locked the duty register tracks the table result continuously.
    always_comb
    begin
        next_duty = duty;
        if (!unlocked)
        begin
            next_duty = lut_duty(lut, remote_temp); // R2
        end
        else if (wr_done && idx == `IDX_DUTY)
        begin
            next_duty = pwdata[7:0]; // R3
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            duty <= `DUTY_RESET;
        end
        else
        begin
            duty <= next_duty;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tach_limit <= `TACH_LIMIT_RESET;
        end
        else if (wr_done && idx == `IDX_TACH_LIMIT)
        begin
            tach_limit <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_mask <= `IRQ_RESET;
        end
        else if (wr_done && idx == `IDX_IRQ_MASK)
        begin
            irq_mask <= pwdata[1:0];
        end
    end

    always_comb
    begin
        ctrl.duty                  = duty;
        ctrl.pwm_base_clock_select = cfg.pwm_base_clock_select;
        ctrl.rpm_sense_mode        = cfg.pwm_base_clock_select ? cfg.rpm_sense_mode
                                                               : mode_plain; // R11
    end

    fan_pwm_core
    #(
        .SLOW_DIV (SLOW_DIV)
    )
    u_core
    (
        .mclk    (mclk),
        .rst     (rst),
        .ctrl    (ctrl),
        .tach_in (tach_in),
        .pwm_on  (pwm_on),
        .report  (report)
    );

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tach_read <= `TACH_READ_RESET;
        end
        else if (report.valid)
        begin
            tach_read <= report.count; // R8
        end
    end

    // Any reading above a lowered limit raises the alarm, even for a healthy fan.
    always_comb
    begin
        irq_set                = 2'h0;
        irq_set[`IRQ_OVER_BIT] = report.valid & (report.count > tach_limit); // R8
        irq_set[`IRQ_LOST_BIT] = report.lost;
        irq_clear              = 2'h0;
        if (wr_done && idx == `IDX_IRQ_STATUS)
        begin
            irq_clear = pwdata[1:0];
        end
    end

    // Set wins over clear so an event in the clearing cycle is not lost.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_status <= `IRQ_RESET;
        end
        else
        begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Open drain: the pin is only ever pulled low, the enable decides when.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fan_pwm_out <= 1'b0;
            fan_pwm_oe  <= 1'b1;
        end
        else
        begin
            fan_pwm_out <= 1'b0;
            fan_pwm_oe  <= ~(pwm_on ^ cfg.fan_output_polarity); // R4
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            smoothing_setting <= `SMOOTH_RESET;
        end
        else
        begin
            smoothing_setting <= smooth;
        end
    end

endmodule

// ==== verif/fan_pwm_tach_config_props.sv ====
`timescale 1ns/100ps

module fan_pwm_tach_config_props
#(
    parameter int unsigned SLOW_DIV = 8
)
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  remote_temp,
    input wire logic        tach_in,
    input wire logic        fan_pwm_out,
    input wire logic        fan_pwm_oe,
    input wire logic [2:0]  smoothing_setting,
    input wire logic        irq
);
    default clocking cb @(posedge mclk);
    endclocking

    ready_pulse_a: assert property (disable iff (rst) pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_wait_a: assert property (disable iff (rst) psel && penable && !pready |=> pready)
        else $error("ready did not follow the first access cycle");
    ready_cause_a: assert property (disable iff (rst) pready |-> $past(psel && penable))
        else $error("ready without an access");
    idle_data_a: assert property (disable iff (rst) !pready |-> prdata == 32'h0)
        else $error("read data not zero outside an answer");
    cfg_spare_a: assert property (disable iff (rst) pready && !pwrite && paddr == 12'h128 |-> prdata[7:6] == 2'h0)
        else $error("spare configuration bits read nonzero");
    drain_only_a: assert property (disable iff (rst) fan_pwm_out == 1'b0)
        else $error("fan pin driven high");
    misalign_err_a: assert property (disable iff (rst) pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("misaligned access not refused");
    reset_off_a: assert property (rst |=> fan_pwm_oe && !irq && smoothing_setting == 3'h0)
        else $error("reset state of outputs wrong");
endmodule

bind fan_pwm_tach_config fan_pwm_tach_config_props #(.SLOW_DIV(SLOW_DIV)) u_props
(
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_temp(remote_temp), .tach_in(tach_in), .fan_pwm_out(fan_pwm_out),
    .fan_pwm_oe(fan_pwm_oe), .smoothing_setting(smoothing_setting), .irq(irq)
);

// ==== verif/fan_model.sv ====
`timescale 1ns/100ps

// A stopped fan gives no edges at all, so the tach line rests low.
module fan_model
(
    input  wire logic        mclk,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             tach
);
    logic [15:0] cnt;

    // With run low the first edge clears both, so no second driver is needed at start.
    always_ff @(posedge mclk)
    begin
        cnt <= (!run || cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
        tach <= run && (cnt < (period >> 1));
    end
endmodule

// ==== verif/fan_pwm_tach_config_test.sv ====
`timescale 1ns/100ps

module fan_pwm_tach_config_test;
    import fan_pwm_tach_pkg::*;

    logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  remote_temp;
    logic        tach_in, fan_pwm_out, fan_pwm_oe, irq, fan_run, e;
    logic [2:0]  smoothing_setting;
    logic [15:0] fan_per;
    int          n_fail, cmp_count, c;

    fan_pwm_tach_config #(.SLOW_DIV(8)) uut
    (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remote_temp(remote_temp), .tach_in(tach_in),
        .fan_pwm_out(fan_pwm_out), .fan_pwm_oe(fan_pwm_oe),
        .smoothing_setting(smoothing_setting), .irq(irq)
    );

    fan_model u_fan (.mclk(mclk), .run(fan_run), .period(fan_per), .tach(tach_in));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The answer is awaited with a bound; a hang ends the run as a failure.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            complete_run();
        end
        else
        begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        check(nm, {q[31:1], q[0] ^ e}, exp);
    endtask

    // Counts cycles in which the fan is on after one settling window.
    task automatic on_count(input int win, input logic pol);
        repeat (win) @(posedge mclk);
        c = 0;
        repeat (win)
        begin
            @(posedge mclk);
            if (fan_pwm_oe === pol)
                c++;
        end
    endtask

    task automatic t_reset();
        rd(12'h128, 32'h20, "cfg reset");
        rd(12'h130, 32'h0, "duty reset");
        rd(12'h1C4, 32'hFFFF, "limit reset");
        check("oe reset", fan_pwm_oe, 32'h1);
    endtask

    task automatic t_cfg_bits();
        wr(12'h128, 32'hDB);
        rd(12'h128, 32'h1B, "cfg spare");
        wr(12'h128, 32'h3B);
        rd(12'h128, 32'h3B, "cfg all");
    endtask

    task automatic t_lock();
        wr(12'h128, 32'h20);
        wr(12'h198, 32'h50);
        wr(12'h19C, 32'h99);
        wr(12'h114, 32'h5);
        wr(12'h128, 32'h00);
        wr(12'h114, 32'h2);
        wr(12'h130, 32'h80);
        check("smoothing locked", smoothing_setting, 32'h5);
        remote_temp <= 8'h40;
        repeat (4) @(posedge mclk);
        rd(12'h130, 32'h0, "duty below step");
        remote_temp <= 8'h60;
        repeat (4) @(posedge mclk);
        rd(12'h130, 32'h99, "duty from table");
        wr(12'h198, 32'h00);
        rd(12'h198, 32'h50, "table locked");
    endtask

    task automatic t_polarity();
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            d = i[0] ? 8'hFF : 8'h00;
            wr(12'h128, {27'h0, i[1], 4'h8} | 32'h20);
            wr(12'h130, {24'h0, d});
            repeat (2100) @(posedge mclk);
            check("pin level", fan_pwm_oe, {31'h0, i[0] ~^ i[1]});
        end
    endtask

    task automatic t_modes();
        logic [7:0] cfg [5] = '{8'h22, 8'h28, 8'h29, 8'h2A, 8'h2B};
        logic [7:0] dty [5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h08};
        int         win [5] = '{17664, 2048, 2048, 4096, 2048};
        int         exp [5] = '{8832, 1024, 1024, 3072, 128};
        for (int i = 0; i < 5; i++)
        begin
            wr(12'h128, {24'h0, cfg[i]});
            wr(12'h130, {24'h0, dty[i]});
            on_count(win[i], 1'b0);
            check("on cycles", c, exp[i]);
        end
    endtask

    task automatic t_tach_irq();
        wr(12'h128, 32'h28);
        wr(12'h1C4, 32'h10);
        fan_per <= 16'd400;
        fan_run <= 1'b1;
        repeat (2000) @(posedge mclk);
        xfer(1'b0, 12'h1C0, 32'h0);
        check("tach count", q >= 49 && q <= 51, 32'h1);
        repeat (3) @(posedge mclk);
        check("irq masked", irq, 32'h0);
        rd(12'h1C8, 32'h1, "status set");
        wr(12'h1CC, 32'h1);
        repeat (3) @(posedge mclk);
        check("irq raised", irq, 32'h1);
        fan_run <= 1'b0;
        repeat (20) @(posedge mclk);
        wr(12'h1C8, 32'h1);
        repeat (3) @(posedge mclk);
        check("irq cleared", irq, 32'h0);
        rd(12'h1C8, 32'h0, "status clear");
    endtask

    task automatic t_refuse();
        xfer(1'b0, 12'h12A, 32'h0);
        check("misaligned err", {e, q[30:0]}, 32'h80000000);
        xfer(1'b1, 12'h300, 32'h1);
        check("unmapped err", e, 32'h1);
    endtask

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, fan_run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        remote_temp = 8'h00;
        fan_per = 16'd400;
        n_fail = 0;
        cmp_count = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_cfg_bits();
        t_lock();
        t_polarity();
        t_modes();
        t_tach_irq();
        t_refuse();
        complete_run();
    end
endmodule
